// ==== hw/dma_chan_addr_ctl.sv ====
/*
 Address and control logic of one DMA channel, Avalon-MM register slave.
 Assumes a data mover that pulses pkt_done after each packet it moves for
 the request shown on pkt_req, and flow-control masters on a request bus.
*/
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`include "dma_chan_consts.svh"

module dma_chan_addr_ctl #(
   parameter int N_MASTERS = `NUM_MASTERS
) (
   // Clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // Avalon-MM slave
   input  wire logic [5:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   // Flow-control interface
   input  wire logic [N_MASTERS-1:0]  flow_req,
   input  wire logic [N_MASTERS-1:0]  flow_term,
   // Data mover
   output dma_chan_pkg::pkt_req_t     pkt_req,
   input  wire logic                  pkt_done,
   // Status
   output logic                       busy,
   output logic                       done
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   dma_chan_pkg::chan_state_t state_q;
   logic        global_on_q;
   logic        chan_on_q;
   logic [31:0] limit_q;
   logic [31:0] periph_q;
   logic [31:0] mem_q;
   logic [31:0] ctl_q;
   logic        rd_pend_q;
   logic [31:0] rd_data_q;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic [31:0] step(input logic [31:0] a, input logic [2:0] sz);
      return a + {29'h0, sz};
   endfunction : step

   logic        wr_fire;
   logic [31:0] ctl_wr;
   logic [2:0]  pkt_size;
   logic        enabled;
   logic        bypass;
   logic        master_req;
   logic        master_term;
   logic        last_pkt;
   logic        cancel;
   logic [6:0]  master_sel;

   assign wr_fire     = avs_write && !avs_waitrequest;
   assign ctl_wr      = merge(ctl_q, avs_writedata, avs_byteenable);
   assign pkt_size    = ctl_q[`CTL_SIZE_HI:`CTL_SIZE_LO];
   assign enabled     = global_on_q && chan_on_q;
   assign bypass      = ctl_q[`CTL_BYPASS];
   assign master_sel  = ctl_q[`CTL_MASTER_HI:`CTL_MASTER_LO];
   assign master_req  = !bypass && flow_req[master_sel];
   assign master_term = !bypass && flow_term[master_sel];
   assign cancel      = ctl_q[`CTL_CANCEL];
   // Limit stops the channel only while the memory pointer moves
   assign last_pkt    = ctl_q[`CTL_INC_MEM] &&
                        (step(mem_q, pkt_size) == limit_q);

   // ---------------------------------------------------------------
   // Avalon-MM: writes and reads each wait one cycle
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         rd_pend_q       <= 1'b0;
         avs_readdata    <= `RST_WORD;
      end else begin
         rd_pend_q       <= avs_read && !rd_pend_q && avs_waitrequest;
         avs_waitrequest <= !((avs_write && avs_waitrequest) ||
                              (avs_read && !rd_pend_q && avs_waitrequest));
         if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_data_q;
         end
      end
   end

   always_comb begin
      case (avs_address)
         `OFS_GLOBAL_ON:  rd_data_q = {31'h0, global_on_q};
         `OFS_CHANNEL_ON: rd_data_q = {31'h0, chan_on_q};
         `OFS_MEM_LIMIT:  rd_data_q = limit_q;
         `OFS_PERIPH_PTR: rd_data_q = periph_q;
         `OFS_CONTROL:    rd_data_q = ctl_q & `CTL_WR_MASK |
                                      {26'h0, busy, 2'h0, done, 2'h0};
         `OFS_MEM_PTR:    rd_data_q = mem_q;
         default:         rd_data_q = `RST_WORD;
      endcase
   end

   // ---------------------------------------------------------------
   // Enables
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         global_on_q <= 1'b0;
         chan_on_q   <= 1'b0;
      end else if (wr_fire && avs_byteenable[0]) begin
         if (avs_address == `OFS_GLOBAL_ON) begin
            global_on_q <= avs_writedata[0];
         end
         if (avs_address == `OFS_CHANNEL_ON) begin
            chan_on_q <= avs_writedata[0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Limit register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         limit_q <= `RST_WORD;
      end else if (wr_fire && avs_address == `OFS_MEM_LIMIT) begin
         limit_q <= merge(limit_q, avs_writedata, avs_byteenable);
      end
   end

   // ---------------------------------------------------------------
   // Pointers: packet advance beats a software write
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         periph_q <= `RST_WORD;
         mem_q    <= `RST_WORD;
      end else begin
         if (state_q == dma_chan_pkg::ST_RUN && pkt_done && ctl_q[`CTL_INC_PERIPH]) begin
            periph_q <= step(periph_q, pkt_size);
         end else if (wr_fire && avs_address == `OFS_PERIPH_PTR) begin
            periph_q <= merge(periph_q, avs_writedata, avs_byteenable);
         end
         if (state_q == dma_chan_pkg::ST_RUN && pkt_done && ctl_q[`CTL_INC_MEM]) begin
            mem_q <= step(mem_q, pkt_size);
         end else if (wr_fire && avs_address == `OFS_MEM_PTR) begin
            mem_q <= merge(mem_q, avs_writedata, avs_byteenable);
         end
      end
   end

   // ---------------------------------------------------------------
   // Control register; kick and cancel clear when consumed
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl_q <= `RST_WORD;
      end else if (wr_fire && avs_address == `OFS_CONTROL) begin
         ctl_q <= ctl_wr & `CTL_WR_MASK;
      end else begin
         if (state_q != dma_chan_pkg::ST_IDLE || !enabled) begin
            ctl_q[`CTL_KICK] <= 1'b0;
         end
         if (state_q != dma_chan_pkg::ST_RUN) begin
            ctl_q[`CTL_CANCEL] <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Channel state machine
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= dma_chan_pkg::ST_IDLE;
      end else begin
         case (state_q)
            dma_chan_pkg::ST_IDLE: begin
               if (enabled && !cancel &&
                   ((bypass && ctl_q[`CTL_KICK]) || master_req)) begin
                  state_q <= dma_chan_pkg::ST_RUN;
               end
            end
            dma_chan_pkg::ST_RUN: begin
               if (!enabled || cancel || master_term) begin
                  state_q <= dma_chan_pkg::ST_DONE;
               end else if (pkt_done && last_pkt) begin
                  state_q <= dma_chan_pkg::ST_DONE;
               end
            end
            dma_chan_pkg::ST_DONE: begin
               state_q <= dma_chan_pkg::ST_IDLE;
            end
            default: begin
               state_q <= dma_chan_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pkt_req <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         pkt_req.addr  <= periph_q;
         pkt_req.dir   <= ctl_q[`CTL_DIR];
         pkt_req.size  <= pkt_size;
         pkt_req.valid <= state_q == dma_chan_pkg::ST_RUN && enabled && !cancel &&
                          !pkt_done && (bypass || master_req);
         busy          <= state_q == dma_chan_pkg::ST_RUN;
         if (state_q == dma_chan_pkg::ST_DONE) begin
            done <= 1'b1;
         end else if (state_q == dma_chan_pkg::ST_RUN || !enabled) begin
            done <= 1'b0;
         end
      end
   end

endmodule : dma_chan_addr_ctl

// ==== hw/dma_chan_consts.svh ====
/*
 Offsets, field positions, reset values and counts of one DMA channel.
 Assumes inclusion by its bare name from the channel module and the bench.
*/
`ifndef DMA_CHAN_CONSTS_SVH
`define DMA_CHAN_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_GLOBAL_ON     6'h00
`define OFS_CHANNEL_ON    6'h04
`define OFS_MEM_LIMIT     6'h08
`define OFS_PERIPH_PTR    6'h0c
`define OFS_CONTROL       6'h10
`define OFS_MEM_PTR       6'h14

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTL_CANCEL        25
`define CTL_KICK          24
`define CTL_SIZE_HI       22
`define CTL_SIZE_LO       20
`define CTL_BYPASS        19
`define CTL_INC_PERIPH    17
`define CTL_INC_MEM       16
`define CTL_MASTER_HI     15
`define CTL_MASTER_LO     9
`define CTL_DIR           8
`define CTL_BUSY          5
`define CTL_DONE          2
`define CTL_WR_MASK       32'h037f_ff00

// ---------------------------------------------------------------
// Reset values and counts
// ---------------------------------------------------------------
`define RST_WORD          32'h0000_0000
`define RD_LATENCY        2'h1
`define NUM_MASTERS       128

`endif

// ==== hw/dma_chan_pkg.sv ====
/*
 Types shared by the DMA channel address and control logic.
 Assumes the constants header is on the include path.
*/
package dma_chan_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN  = 2'b01,
      ST_DONE = 2'b10
   } chan_state_t;

   typedef struct packed {
      logic [31:0] addr;
      logic        dir;
      logic [2:0]  size;
      logic        valid;
   } pkt_req_t;

endpackage : dma_chan_pkg

// ==== verif/dma_chan_addr_ctl_props.sv ====
/*
 Concurrent checks on the ports of the DMA channel address and control block.
 Assumes one clock, ref_clk, and a synchronous active-high reset, rst.
*/
`timescale 1ns/1ps
module dma_chan_addr_ctl_props (
   // Clock and reset
   input wire logic                   ref_clk,
   input wire logic                   rst,
   // Register bus
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   // Channel
   input wire dma_chan_pkg::pkt_req_t pkt_req,
   input wire logic                   pkt_done,
   input wire logic                   busy,
   input wire logic                   done
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest not lowered after a request");
   chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest lowered without a request");
   chk_read_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   chk_valid_run: assert property (pkt_req.valid |-> busy || $past(busy))
      else $error("packet request outside a run");
   chk_done_idle: assert property ($rose(done) |-> !busy)
      else $error("done raised while busy");
   chk_done_clear: assert property ($rose(busy) |-> ##[0:1] !done)
      else $error("done not cleared by a new run");
   chk_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !busy && !done && !pkt_req.valid)
      else $error("outputs not at reset values");
   cover property ($rose(busy));
   cover property ($rose(done));
   cover property (pkt_done && busy);
endmodule : dma_chan_addr_ctl_props

bind dma_chan_addr_ctl dma_chan_addr_ctl_props u_props (
   .ref_clk(ref_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .pkt_req(pkt_req), .pkt_done(pkt_done), .busy(busy), .done(done));

// ==== verif/dma_chan_addr_ctl_test.sv ====
/*
 Self-checking bench for the DMA channel address and control block.
 Assumes package, header, mover model and checker compiled before it.
*/
`timescale 1ns/1ps
`include "dma_chan_consts.svh"
module dma_chan_addr_ctl_test;
   localparam logic [31:0] zero = 32'h0000_0000;
   localparam logic [31:0] one  = 32'h0000_0001;
   logic                   ref_clk, rst, avs_read, avs_write, avs_waitrequest;
   logic [5:0]             avs_address;
   logic [31:0]            avs_writedata, avs_readdata, seen_addr, rdv;
   logic [127:0]           flow_req, flow_term;
   dma_chan_pkg::pkt_req_t pkt_req;
   logic                   pkt_done, busy, done;
   logic [3:0]             lat;
   int                     n_pkts, n_errors, check_count;

   dma_chan_addr_ctl u_dut (
      .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .flow_req(flow_req),
      .flow_term(flow_term), .pkt_req(pkt_req), .pkt_done(pkt_done), .busy(busy), .done(done));
   pkt_mover_model u_mover (
      .ref_clk(ref_clk), .rst(rst), .pkt_req(pkt_req), .pkt_done(pkt_done), .lat(lat),
      .seen_addr(seen_addr), .n_pkts(n_pkts));

   // ----------------------------------------
   // Bus cycle, compare and wait helpers
   // ----------------------------------------
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      // Only the watchdog ends a wait for the slave's answer
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wt(input logic v, input int lim);
      for (int i = 0; i < lim && busy !== v; i++) @(posedge ref_clk);
   endtask : wt

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      bus(0, `OFS_MEM_LIMIT, zero);
      check("limit_reset", rdv, zero);
      bus(1, `OFS_CONTROL, 32'hfc80_00c0);
      bus(0, `OFS_CONTROL, zero);
      check("ctl_reserved", rdv, zero);
      bus(1, 6'h3c, 32'hffff_ffff);
      bus(0, 6'h3c, zero);
      check("unmapped", rdv, zero);
      bus(1, `OFS_PERIPH_PTR, 32'h1234_5678);
      bus(0, `OFS_PERIPH_PTR, zero);
      check("pptr_rw", rdv, 32'h1234_5678);
      $display("test regs finished");
   endtask : t_regs
   task automatic t_run;
      logic [31:0] s;
      int          base;
      bus(1, `OFS_GLOBAL_ON, one);
      bus(1, `OFS_CHANNEL_ON, one);
      for (int i = 0; i < 3; i++) begin
         s = one << i;
         base = n_pkts;
         lat <= 4'(i * 6);
         bus(1, `OFS_MEM_PTR, 32'h0000_0100);
         bus(1, `OFS_MEM_LIMIT, 32'h0000_0100 + 3 * s);
         bus(1, `OFS_PERIPH_PTR, 32'h0000_2000);
         bus(1, `OFS_CONTROL, 32'h010b_0000 | (s << 20));
         wt(1, 20);
         check("pkt_size", {29'h0, pkt_req.size}, s);
         wt(0, 400);
         check("run_pkts", 32'(n_pkts - base), 32'h0000_0003);
         check("run_done", {31'h0, done}, one);
         check("dev_addr", seen_addr, 32'h0000_2000 + 2 * s);
         bus(0, `OFS_PERIPH_PTR, zero);
         check("pptr_step", rdv, 32'h0000_2000 + 3 * s);
         bus(0, `OFS_MEM_PTR, zero);
         check("mptr_step", rdv, 32'h0000_0100 + 3 * s);
      end
      $display("test run finished");
   endtask : t_run
   task automatic t_cancel;
      bus(1, `OFS_MEM_LIMIT, 32'h0000_010d);
      bus(1, `OFS_CONTROL, 32'h011a_0000);
      repeat (60) @(posedge ref_clk);
      check("no_self_end", {31'h0, busy}, one);
      bus(1, `OFS_CONTROL, 32'h021a_0000);
      wt(0, 4);
      check("cancel_end", {31'h0, busy}, zero);
      bus(0, `OFS_CONTROL, zero);
      check("ctl_clear", rdv & 32'h03ff_ff00, 32'h001a_0000);
      $display("test cancel finished");
   endtask : t_cancel
   task automatic t_flow;
      lat <= 4'h0;
      bus(1, `OFS_CHANNEL_ON, zero);
      bus(1, `OFS_PERIPH_PTR, 32'h0000_3000);
      bus(1, `OFS_CONTROL, 32'h0000_0a00);
      flow_req[5] <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check("off_idle", {31'h0, busy}, zero);
      bus(1, `OFS_CONTROL, 32'h0008_0a00);
      bus(1, `OFS_CHANNEL_ON, one);
      repeat (10) @(posedge ref_clk);
      check("bypass_idle", {31'h0, busy}, zero);
      bus(1, `OFS_CONTROL, 32'h0000_0a00);
      wt(1, 20);
      check("flow_start", {31'h0, busy}, one);
      repeat (10) @(posedge ref_clk);
      flow_req[5] <= 1'b0;
      flow_term[5] <= 1'b1;
      wt(0, 20);
      check("flow_end", {31'h0, busy}, zero);
      check("dev_fixed", seen_addr, 32'h0000_3000);
      flow_term[5] <= 1'b0;
      $display("test flow finished");
   endtask : t_flow

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end
   initial begin
      {rst, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h00_0000_0000};
      {flow_req, flow_term, lat} = '0;
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      t_regs();
      t_run();
      t_cancel();
      t_flow();
      print_verdict();
   end
endmodule : dma_chan_addr_ctl_test

// ==== verif/pkt_mover_model.sv ====
/*
 Behavioural data mover at the far side of one DMA channel.
 Assumes a packet request that stays valid while the channel runs.
*/
`timescale 1ns/1ps
module pkt_mover_model (
   // Clock and reset
   input  wire logic                   ref_clk,
   input  wire logic                   rst,
   // Channel side
   input  wire dma_chan_pkg::pkt_req_t pkt_req,
   output logic                        pkt_done,
   // Bench side
   input  wire logic [3:0]             lat,
   output logic [31:0]                 seen_addr,
   output int                          n_pkts
);
   logic [4:0] cnt_q;
   // Gap after each packet lets the advanced pointer reach pkt_req
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= 5'h00;
      end else if (cnt_q == 5'h00) begin
         if (pkt_req.valid) begin
            cnt_q <= 5'h01;
            seen_addr <= pkt_req.addr;
         end
      end else begin
         cnt_q <= (cnt_q == 5'(lat) + 5'h03) ? 5'h00 : cnt_q + 5'h01;
      end
   end
   always_ff @(posedge ref_clk) begin
      pkt_done <= !rst && cnt_q == 5'(lat) + 5'h01;
      n_pkts <= rst ? 0 : n_pkts + int'(cnt_q == 5'(lat) + 5'h01);
   end
endmodule : pkt_mover_model
